// *** hdl/adcr_clkdiv.sv ***
// conversion clock divider: one tick every 2**cks system clocks
// assumes: cks comes from a register on the same clock
`timescale 1ns/1ps
module adcr_clkdiv
  import adcr_pkg::*;
#(
  parameter int DIV_W = `ADCR_DIV_W
) (
  // clock and reset
  input  wire logic       ref_clk,
  input  wire logic       reset_n,
  // control
  input  wire logic [2:0] cks,
  // divided strobe
  output logic            tick
);

  initial begin
    if (DIV_W != `ADCR_DIV_W) $error("adcr_clkdiv: DIV_W unsupported");
  end

  adcr_div_s              s_r;
  adcr_div_s              s_nxt;
  logic [`ADCR_DIV_W-1:0] limit;

  always_comb begin
    limit = `ADCR_DIV_MAX >> (`ADCR_CKS_MAX - cks);
    s_nxt = s_r;
    s_nxt.tick = (s_r.count >= limit);
    if (s_r.count >= limit) begin
      s_nxt.count = '0;
    end else begin
      s_nxt.count = s_r.count + 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign tick = s_r.tick;

endmodule

// *** hdl/adcr_params.svh ***
// constants for the converter control and result register block
// assumes: included only by the package, which is compiled ahead of every design module
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH

// ----------------------------------------------------------------
// widths
// ----------------------------------------------------------------
`define ADCR_RES_W      12
`define ADCR_IDX_W      4
`define ADCR_DIV_W      7
`define ADCR_BYTE_W     8

// ----------------------------------------------------------------
// apb byte offsets
// ----------------------------------------------------------------
`define ADCR_OFF_RES_LOW  8'h00
`define ADCR_OFF_RES_HIGH 8'h04
`define ADCR_OFF_CTL0     8'h08
`define ADCR_OFF_CTL1     8'h0C
`define ADCR_OFF_CTL2     8'h10
`define ADCR_OFF_BG       8'h14
`define ADCR_OFF_INT_STAT 8'h18
`define ADCR_OFF_INT_EN   8'h1C
`define ADCR_OFF_INT_CLR  8'h20

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ADCR_C0_START   7
`define ADCR_C0_BUSY    6
`define ADCR_C0_EN      5
`define ADCR_C0_ALIGN   4
`define ADCR_C0_CHAN    3:0
`define ADCR_C1_INS     7:4
`define ADCR_C1_CKS     2:0
`define ADCR_C2_AMPEN   7
`define ADCR_C2_AMPIS   4
`define ADCR_C2_REF     3:2
`define ADCR_C2_GAIN    1:0
`define ADCR_BG_EN      0
`define ADCR_INT_DONE   0

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define ADCR_RST_BYTE   8'h00
`define ADCR_RST_WORD   32'h0000_0000
`define ADCR_INS_EXT_A  4'h0
`define ADCR_INS_EXT_B  4'h4
`define ADCR_INS_EXT_HI 2'h3
`define ADCR_DIV_MAX    7'h7F
`define ADCR_CKS_MAX    3'h7

`endif

// *** hdl/adcr_pkg.sv ***
// types shared by the converter control block and its helpers
// assumes: adcr_params.svh sits on the include path
`include "adcr_params.svh"
package adcr_pkg;

  typedef enum logic [0:0] {
    ADCR_IDLE = 1'b0,
    ADCR_CONV = 1'b1
  } adcr_sar_state_e;

  typedef struct packed {
    adcr_sar_state_e          st;
    logic [`ADCR_IDX_W-1:0]   idx;
    logic [`ADCR_RES_W-1:0]   code;
    logic [`ADCR_RES_W-1:0]   result;
    logic                     done;
  } adcr_sar_s;

  typedef struct packed {
    logic [`ADCR_DIV_W-1:0]   count;
    logic                     tick;
  } adcr_div_s;

  typedef struct packed {
    logic                     start;
    logic                     busy;
    logic                     enable;
    logic                     align;
    logic [3:0]               chan;
    logic [3:0]               ins;
    logic [2:0]               cks;
    logic                     amp_en;
    logic                     amp_is;
    logic [1:0]               refs;
    logic [1:0]               gain;
    logic                     bg_en;
    logic [`ADCR_RES_W-1:0]   result;
    logic                     int_stat;
    logic                     int_en;
    logic                     go;
    logic                     comp_s1;
    logic                     comp_s2;
    logic [31:0]              prdata;
  } adcr_top_s;

endpackage

// *** hdl/adcr_sar.sv ***
// successive approximation sequencer, one result bit per tick
// assumes: comp_in is already synchronised to ref_clk
`timescale 1ns/1ps
module adcr_sar
  import adcr_pkg::*;
#(
  parameter int RES_W = `ADCR_RES_W
) (
  // clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset_n,
  // control
  input  wire logic             tick,
  input  wire logic             go,
  input  wire logic             abort,
  input  wire logic             comp_in,
  // results
  output logic [RES_W-1:0]      dac_code,
  output logic [RES_W-1:0]      result,
  output logic                  done,
  output logic                  active
);

  initial begin
    if (RES_W != `ADCR_RES_W) $error("adcr_sar: RES_W unsupported");
  end

  adcr_sar_s s_r;
  adcr_sar_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    case (s_r.st)
      ADCR_IDLE: begin
        if (go && !abort) begin
          s_nxt.st = ADCR_CONV;
          s_nxt.idx = `ADCR_IDX_W'(RES_W - 1);
          s_nxt.code = '0;
          s_nxt.code[RES_W-1] = 1'b1;
        end
      end
      ADCR_CONV: begin
        if (abort) begin
          s_nxt.st = ADCR_IDLE;
        end else if (tick) begin
          if (!comp_in) begin
            s_nxt.code[s_r.idx] = 1'b0;
          end
          if (s_r.idx == '0) begin
            s_nxt.st = ADCR_IDLE;
            s_nxt.done = 1'b1;
            s_nxt.result = s_nxt.code;
          end else begin
            s_nxt.idx = s_r.idx - 1'b1;
            s_nxt.code[s_r.idx - 1'b1] = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.st = ADCR_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign dac_code = s_r.code;
  assign result   = s_r.result;
  assign done     = s_r.done;
  assign active   = (s_r.st == ADCR_CONV);

endmodule

// *** hdl/adcr_top.sv ***
// converter control and result registers behind an apb slave
// assumes: analog converter, amplifier and bandgap sit outside;
// comp_in comes from the analog comparator (asynchronous)
//
// Overview of operation
// - a 12-bit result is held as a high byte and a low byte.
// - align clear puts 11..4 high, 3..0 low top; set puts 11..8, 7..0.
// - data bits not holding result bits read back as zero.
// - with the converter disabled both result bytes keep their value.
// - an internal input source disconnects the external channel input.
// - control reg0: start, busy, enable, align, 4-bit channel select.
// - control reg1: input source in 7..4, clock select in 2..0.
// - control reg2: amp enable, amp input, reference, gain fields.
// - bandgap register holds a single enable bit at bit 0.
// - an analog-assigned pin loses its digital function and pull-up.
// - result registers are read-only; writes change nothing.
// - busy sets when start goes high then low; clears at completion.
// - converter enable powers the converter; clearing it powers down.
// - clock select divides the system clock by 1 up to 128.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
module adcr_top
  import adcr_pkg::*;
#(
  parameter int NUM_PINS = 8
) (
  // clock and reset
  input  wire logic                   ref_clk,
  input  wire logic                   reset_n,
  // apb slave
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [7:0]             paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  // interrupt
  output logic                        irq,
  // analog converter side
  input  wire logic                   comp_in,
  output logic [`ADCR_RES_W-1:0]      dac_code,
  output logic                        conv_strobe,
  output logic                        conv_active,
  output logic                        conv_power_en,
  output logic                        ext_chan_connect,
  output logic [3:0]                  ext_chan_sel,
  output logic [3:0]                  int_src_sel,
  output logic                        amp_enable,
  output logic                        amp_input_select,
  output logic [1:0]                  ref_select,
  output logic [1:0]                  amp_gain_select,
  output logic                        bandgap_enable,
  // pin sharing
  input  wire logic [NUM_PINS-1:0]    pin_analog_sel,
  input  wire logic [NUM_PINS-1:0]    pin_pullup_req,
  output logic [NUM_PINS-1:0]         pin_pullup_en,
  output logic [NUM_PINS-1:0]         pin_digital_en
);

  initial begin
    if (NUM_PINS < 1) $error("adcr_top: NUM_PINS must be positive");
  end

  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  adcr_top_s                s_r;
  adcr_top_s                s_nxt;
  logic                     tick;
  logic                     sar_done;
  logic                     sar_active;
  logic [`ADCR_RES_W-1:0]   sar_result;
  logic                     setup;
  logic                     wr_acc;
  logic                     hit;
  logic                     is_ext;
  logic [7:0]               wbyte;
  logic [7:0]               rbyte;
  logic                     div_rst_n;

  assign setup  = psel && !penable;
  assign wr_acc = psel && penable && pwrite && pstrb[0];
  assign wbyte  = pwdata[7:0];

  // restart the divider at launch so that the first trial bit gets a
  // full conversion clock period for the comparator path to settle
  assign div_rst_n = reset_n && !s_r.go;

  always_comb begin
    case (paddr)
      `ADCR_OFF_RES_LOW, `ADCR_OFF_RES_HIGH, `ADCR_OFF_CTL0,
      `ADCR_OFF_CTL1, `ADCR_OFF_CTL2, `ADCR_OFF_BG,
      `ADCR_OFF_INT_STAT, `ADCR_OFF_INT_EN,
      `ADCR_OFF_INT_CLR: hit = 1'b1;
      default:           hit = 1'b0;
    endcase
  end

  // codes 0000, 0100 and 11xx select the external channel
  assign is_ext = (s_r.ins == `ADCR_INS_EXT_A) ||
                  (s_r.ins == `ADCR_INS_EXT_B) ||
                  (s_r.ins[3:2] == `ADCR_INS_EXT_HI);

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  always_comb begin
    rbyte = `ADCR_RST_BYTE;
    case (paddr)
      `ADCR_OFF_RES_LOW: begin
        if (s_r.align) begin
          rbyte = s_r.result[7:0];
        end else begin
          rbyte[7:4] = s_r.result[3:0];
        end
      end
      `ADCR_OFF_RES_HIGH: begin
        if (s_r.align) begin
          rbyte[3:0] = s_r.result[11:8];
        end else begin
          rbyte = s_r.result[11:4];
        end
      end
      `ADCR_OFF_CTL0: begin
        rbyte[`ADCR_C0_START] = s_r.start;
        rbyte[`ADCR_C0_BUSY]  = s_r.busy;
        rbyte[`ADCR_C0_EN]    = s_r.enable;
        rbyte[`ADCR_C0_ALIGN] = s_r.align;
        rbyte[`ADCR_C0_CHAN]  = s_r.chan;
      end
      `ADCR_OFF_CTL1: begin
        rbyte[`ADCR_C1_INS] = s_r.ins;
        rbyte[`ADCR_C1_CKS] = s_r.cks;
      end
      `ADCR_OFF_CTL2: begin
        rbyte[`ADCR_C2_AMPEN] = s_r.amp_en;
        rbyte[`ADCR_C2_AMPIS] = s_r.amp_is;
        rbyte[`ADCR_C2_REF]   = s_r.refs;
        rbyte[`ADCR_C2_GAIN]  = s_r.gain;
      end
      `ADCR_OFF_BG:       rbyte[`ADCR_BG_EN] = s_r.bg_en;
      `ADCR_OFF_INT_STAT: rbyte[`ADCR_INT_DONE] = s_r.int_stat;
      `ADCR_OFF_INT_EN:   rbyte[`ADCR_INT_DONE] = s_r.int_en;
      default:            rbyte = `ADCR_RST_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    s_nxt.go = 1'b0;
    s_nxt.comp_s1 = comp_in;
    s_nxt.comp_s2 = s_r.comp_s1;
    if (setup && !pwrite) begin
      s_nxt.prdata = {24'h00_0000, rbyte};
    end
    if (wr_acc) begin
      case (paddr)
        `ADCR_OFF_CTL0: begin
          s_nxt.start  = wbyte[`ADCR_C0_START];
          s_nxt.enable = wbyte[`ADCR_C0_EN];
          s_nxt.align  = wbyte[`ADCR_C0_ALIGN];
          s_nxt.chan   = wbyte[`ADCR_C0_CHAN];
        end
        `ADCR_OFF_CTL1: begin
          s_nxt.ins = wbyte[`ADCR_C1_INS];
          s_nxt.cks = wbyte[`ADCR_C1_CKS];
        end
        `ADCR_OFF_CTL2: begin
          s_nxt.amp_en = wbyte[`ADCR_C2_AMPEN];
          s_nxt.amp_is = wbyte[`ADCR_C2_AMPIS];
          s_nxt.refs   = wbyte[`ADCR_C2_REF];
          s_nxt.gain   = wbyte[`ADCR_C2_GAIN];
        end
        `ADCR_OFF_BG:     s_nxt.bg_en = wbyte[`ADCR_BG_EN];
        `ADCR_OFF_INT_EN: s_nxt.int_en = wbyte[`ADCR_INT_DONE];
        `ADCR_OFF_INT_CLR: begin
          if (wbyte[`ADCR_INT_DONE]) begin
            s_nxt.int_stat = 1'b0;
          end
        end
        default: s_nxt.go = 1'b0; // result registers ignore writes
      endcase
    end
    // start falling edge launches a conversion
    if (s_r.start && !s_nxt.start && s_r.enable && s_nxt.enable &&
        !s_r.busy) begin
      s_nxt.busy = 1'b1;
      s_nxt.go = 1'b1;
    end
    if (sar_done) begin
      s_nxt.busy = 1'b0;
      s_nxt.result = sar_result;
      s_nxt.int_stat = 1'b1; // set wins over clear
    end
    if (!s_r.enable) begin
      s_nxt.busy = 1'b0;
      s_nxt.go = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  adcr_clkdiv u_div (
    .ref_clk (ref_clk),
    .reset_n (div_rst_n),
    .cks     (s_r.cks),
    .tick    (tick)
  );

  adcr_sar u_sar (
    .ref_clk  (ref_clk),
    .reset_n  (reset_n),
    .tick     (tick),
    .go       (s_r.go),
    .abort    (!s_r.enable),
    .comp_in  (s_r.comp_s2),
    .dac_code (dac_code),
    .result   (sar_result),
    .done     (sar_done),
    .active   (sar_active)
  );

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata           = s_r.prdata;
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !hit;
  assign irq              = s_r.int_stat && s_r.int_en;
  assign conv_strobe      = tick && sar_active;
  assign conv_active      = sar_active;
  assign conv_power_en    = s_r.enable;
  assign ext_chan_connect = is_ext && s_r.enable;
  assign ext_chan_sel     = s_r.chan;
  assign int_src_sel      = s_r.ins;
  assign amp_enable       = s_r.amp_en;
  assign amp_input_select = s_r.amp_is;
  assign ref_select       = s_r.refs;
  assign amp_gain_select  = s_r.gain;
  assign bandgap_enable   = s_r.bg_en;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign pin_pullup_en[gi]  = pin_pullup_req[gi] &&
                                  !pin_analog_sel[gi];
      assign pin_digital_en[gi] = !pin_analog_sel[gi];
    end
  endgenerate

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  sequence start_fall_s;
    s_r.start && !s_nxt.start && s_r.enable && s_nxt.enable &&
    !s_r.busy && reset_n;
  endsequence

  sequence conv_launch_s;
    s_r.go ##1 sar_active;
  endsequence

  busy_set_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    start_fall_s |=> s_r.busy ##0 conv_launch_s)
    else $error("busy not set or conversion not launched");

  busy_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sar_done |=> !s_r.busy && !sar_active)
    else $error("busy not cleared after completion");

  result_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sar_done |=> s_r.result == $past(sar_result))
    else $error("result pair not loaded at completion");

  result_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!s_r.enable [*2]) |=> $stable(s_r.result))
    else $error("result changed while disabled");

  result_ro_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (wr_acc && (paddr == `ADCR_OFF_RES_HIGH || paddr == `ADCR_OFF_RES_LOW)
     && !sar_done) |=> $stable(s_r.result))
    else $error("write changed a result register");

  high_align_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (setup && !pwrite && paddr == `ADCR_OFF_RES_HIGH && !s_r.align)
    |=> prdata == {24'h00_0000, $past(s_r.result[11:4])})
    else $error("high byte misaligned");

  low_align_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (setup && !pwrite && paddr == `ADCR_OFF_RES_LOW && !s_r.align)
    |=> prdata[3:0] == 4'h0 &&
        prdata[7:4] == $past(s_r.result[3:0]))
    else $error("low byte unused bits not zero");

  ext_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !is_ext |-> !ext_chan_connect)
    else $error("external channel connected with internal source");

  pullup_off_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (pin_analog_sel & (pin_pullup_en | pin_digital_en)) == '0)
    else $error("analog pin kept pull-up or digital function");

  div_one_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (s_r.cks == 3'h0 && !s_r.go) [*3] |-> tick)
    else $error("divide by one not ticking every cycle");

  power_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    !s_r.enable |-> !conv_power_en ##1 !sar_active)
    else $error("converter not powered down");

  div_restart_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    s_r.go |=> !tick)
    else $error("divider not restarted at launch");

  done_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    sar_done |=> s_r.int_stat)
    else $error("completion did not set the status bit");

endmodule

// *** verif/adcr_tb.sv ***
// self-checking bench for the converter control and result registers
// assumes: adcr_pkg and adcr_top compiled first; one 100 MHz clock
`timescale 1ns/1ps
module testbench
  import adcr_pkg::*;
;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk, reset_n, psel, penable, pwrite, comp_in;
  logic [7:0]  paddr, pin_analog_sel, pin_pullup_req;
  logic [7:0]  pin_pullup_en, pin_digital_en;
  logic [31:0] pwdata, prdata, lf, rd;
  logic [3:0]  pstrb, ext_chan_sel, int_src_sel;
  logic        pready, pslverr, irq, conv_strobe, conv_active;
  logic        conv_power_en, ext_chan_connect, amp_enable;
  logic        amp_input_select, bandgap_enable, err, known;
  logic [1:0]  ref_select, amp_gain_select;
  logic [11:0] dac_code, target, last_res;
  logic [7:0]  r;
  int          bad_count, compares;
  int          strobes = 0;

  adcr_top dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .irq, .comp_in,
    .dac_code, .conv_strobe, .conv_active, .conv_power_en,
    .ext_chan_connect, .ext_chan_sel, .int_src_sel, .amp_enable,
    .amp_input_select, .ref_select, .amp_gain_select, .bandgap_enable,
    .pin_analog_sel, .pin_pullup_req, .pin_pullup_en, .pin_digital_en);

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // ideal comparator: keeps the trial bit while the code is not above
  always @(posedge ref_clk) begin
    comp_in <= (dac_code <= target);
  end

  // conversion clock ticks seen while converting
  always @(posedge ref_clk) begin
    if (conv_strobe === 1'b1) strobes <= strobes + 1;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
  endfunction

  function automatic logic [31:0] hi(input logic [11:0] v, input logic a);
    return a ? {28'h0, v[11:8]} : {24'h0, v[11:4]};
  endfunction

  function automatic logic [31:0] lo(input logic [11:0] v, input logic a);
    return a ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0};
  endfunction

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", bad_count, compares);
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s = 4'hF);
    int n;
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // one conversion at divider code k, result alignment al
  task automatic conv(input logic [2:0] k, input logic al);
    time t0;
    int  c;
    int  s0;
    lf = lfsr(lf);
    target = lf[11:0];
    apb(1'b1, 8'h0C, {29'h0, k});
    apb(1'b1, 8'h08, {24'h0, 3'b101, al, lf[15:12]});
    apb(1'b1, 8'h08, {24'h0, 3'b001, al, lf[15:12]});
    t0 = $time;
    s0 = strobes;
    rdchk(8'h08, {24'h0, 3'b011, al, lf[15:12]});
    if (known && k > 2) rdchk(8'h04, hi(last_res, al));
    c = 0;
    while (conv_active === 1'b1 && c < 3000) begin
      @(posedge ref_clk);
      c++;
    end
    if (c >= 3000) begin
      bad_count++;
      finish_test();
    end
    chk(strobes - s0, 12);
    c = int'(($time - t0) / 10);
    chk(c >= (12 << k) && c <= (13 << k) + 6, 1);
    rdchk(8'h08, {24'h0, 3'b001, al, lf[15:12]});
    rdchk(8'h18, 32'h1);
    if (k > 1) begin
      last_res = target;
      known = 1'b1;
      rdchk(8'h04, hi(last_res, al));
      rdchk(8'h00, lo(last_res, al));
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    {psel, penable, pwrite, known} = '0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pstrb = 4'h0;
    pin_analog_sel = 8'h00;
    pin_pullup_req = 8'h00;
    target = 12'h000;
    last_res = 12'h000;
    bad_count = 0;
    compares = 0;
    lf = 32'h8041876A;
    reset_n = 1'b0;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 9; i++) rdchk(8'(i * 4), 32'h0);
    chk(irq, 0);
    apb(1'b0, 8'h24, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    apb(1'b1, 8'hFC, 32'hFF);
    chk(err, 1);
    for (int i = 0; i < 6; i++) begin
      lf = lfsr(lf);
      r = lf[7:0];
      pin_analog_sel <= lf[15:8];
      pin_pullup_req <= lf[23:16];
      apb(1'b1, 8'h0C, {24'h0, r});
      rdchk(8'h0C, {24'h0, r & 8'hF7});
      chk(int_src_sel, r[7:4]);
      apb(1'b1, 8'h10, {24'h0, r});
      rdchk(8'h10, {24'h0, r & 8'h9F});
      chk({amp_enable, amp_input_select, ref_select, amp_gain_select},
          {r[7], r[4], r[3:0]});
      apb(1'b1, 8'h10, {24'h0, ~r}, 4'hE);
      rdchk(8'h10, {24'h0, r & 8'h9F});
      apb(1'b1, 8'h14, {24'h0, r});
      rdchk(8'h14, {31'h0, r[0]});
      chk(bandgap_enable, r[0]);
      apb(1'b1, 8'h08, {24'h0, r & 8'h3F | 8'h40});
      rdchk(8'h08, {24'h0, r & 8'h3F});
      chk({conv_power_en, ext_chan_sel}, {r[5], r[3:0]});
      chk({pin_pullup_en, pin_digital_en},
          {lf[23:16] & ~lf[15:8], ~lf[15:8]});
    end
    apb(1'b1, 8'h08, 32'h20);
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 8'h0C, 32'(i << 4));
      @(posedge ref_clk);
      chk(ext_chan_connect, i == 0 || i == 4 || i >= 12);
    end
    for (int k = 0; k < 8; k++) conv(3'(k), 1'(k));
    chk(irq, 0);
    apb(1'b1, 8'h1C, 32'h1);
    @(posedge ref_clk);
    chk(irq, 1);
    apb(1'b1, 8'h20, 32'h1);
    @(posedge ref_clk);
    chk(irq, 0);
    rdchk(8'h18, 32'h0);
    apb(1'b1, 8'h00, 32'hFF);
    apb(1'b1, 8'h04, 32'hFF);
    rdchk(8'h04, hi(last_res, 1'b1));
    rdchk(8'h00, lo(last_res, 1'b1));
    apb(1'b1, 8'h0C, 32'h7);
    apb(1'b1, 8'h08, 32'hA0);
    apb(1'b1, 8'h08, 32'h20);
    repeat (100) @(posedge ref_clk);
    apb(1'b1, 8'h08, 32'h00);
    rdchk(8'h08, 32'h0);
    chk({conv_active, ext_chan_connect, conv_power_en}, 0);
    apb(1'b1, 8'h08, 32'h80);
    apb(1'b1, 8'h08, 32'h00);
    rdchk(8'h08, 32'h0);
    repeat (300) @(posedge ref_clk);
    rdchk(8'h04, hi(last_res, 1'b0));
    rdchk(8'h00, lo(last_res, 1'b0));
    rdchk(8'h18, 32'h0);
    finish_test();
  end
endmodule
